// [logic/ubm_pkg.sv]
package ubm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_A_ADDR = 8'h00;
  localparam logic [7:0] OFS_A_IGN = 8'h04;
  localparam logic [7:0] OFS_A_SEL = 8'h08;
  localparam logic [7:0] OFS_B_ADDR = 8'h0c;
  localparam logic [7:0] OFS_B_IGN = 8'h10;
  localparam logic [7:0] OFS_B_SEL = 8'h14;
  localparam logic [7:0] OFS_B_VAL = 8'h18;
  localparam logic [7:0] OFS_B_VIGN = 8'h1c;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  // cycle select fields: [1:0] master, [3:2] kind, [5:4] dir, [7:6] size
  localparam int SEL_MST_LSB = 0;
  localparam int SEL_KND_LSB = 2;
  localparam int SEL_DIR_LSB = 4;
  localparam int SEL_SIZ_LSB = 6;
  // 2-bit codes: 00 = no condition
  localparam logic [1:0] MST_CPU = 2'h1;
  localparam logic [1:0] MST_DMA = 2'h2;
  localparam logic [1:0] KND_FETCH = 2'h1;
  localparam logic [1:0] KND_DATA = 2'h2;
  localparam logic [1:0] DIR_RD = 2'h1;
  localparam logic [1:0] DIR_WR = 2'h2;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  localparam logic [1:0] SIZ_WORD = 2'h2;
  localparam logic [1:0] SIZ_LONG = 2'h3;
  // control bits
  localparam int CTL_SEQ = 0;
  localparam int CTL_AFTER_A = 1;
  localparam int CTL_AFTER_B = 2;
  localparam int CTL_LEGACY = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam int SETTLE_CYC = 3;
  localparam logic [3:0] MASK_LEVEL_MAX = 4'he;
endpackage : ubm_pkg

// [logic/ubm_chan.sv]
`timescale 1ns/1ns
module ubm_chan
  import ubm_pkg::*;
(
  input wire logic [31:0] match_address,
  input wire logic [31:0] address_ignore,
  input wire logic [7:0] cycle_select,
  input wire logic use_value,
  input wire logic [31:0] match_value,
  input wire logic [31:0] value_ignore,
  input wire logic legacy,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_data,
  input wire logic [1:0] bus_master,
  input wire logic [1:0] bus_kind,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  input wire logic bus_external,
  output logic hit
);
  logic [1:0] mst, knd, dir, siz;
  logic [31:0] care, diff;
  logic m_mst, m_knd, m_dir, m_siz, m_adr, m_val;
  assign mst = cycle_select[SEL_MST_LSB +: 2];
  assign knd = cycle_select[SEL_KND_LSB +: 2];
  assign dir = cycle_select[SEL_DIR_LSB +: 2];
  assign siz = cycle_select[SEL_SIZ_LSB +: 2];
  assign care = ~address_ignore;
  assign diff = (bus_addr ^ match_address) & care;
  always_comb begin
    m_mst = (mst == 2'h0) || (mst == bus_master);
    // dma never fetches instructions, so this pair can never hit
    m_knd = ((knd == 2'h0) || (knd == bus_kind))
      && !(mst == MST_DMA && knd == KND_FETCH);
    m_dir = (dir == 2'h0) || (dir == (bus_write ? DIR_WR : DIR_RD));
    m_siz = (siz == 2'h0) || (siz == bus_size);
    if (legacy || bus_kind == KND_FETCH) begin
      m_adr = (diff == 32'h0000_0000);
    end else begin
      case (bus_size)
        SIZ_LONG: m_adr = (diff[31:2] == 30'h0000_0000);
        SIZ_WORD: m_adr = (diff[31:1] == 31'h0000_0000);
        default: m_adr = (diff == 32'h0000_0000);
      endcase
    end
    m_val = !use_value || (((bus_data ^ match_value) & ~value_ignore) == 32'h0000_0000);
  end
  assign hit = m_mst && m_knd && m_dir && m_siz && m_adr && m_val
    && !(legacy && bus_external);
endmodule : ubm_chan

// [logic/ubm_top.sv]
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module ubm_top
  import ubm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pmaster_cpu,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_data,
  input wire logic [1:0] bus_master,
  input wire logic [1:0] bus_kind,
  input wire logic bus_write,
  input wire logic [1:0] bus_size,
  input wire logic bus_external,
  input wire logic fetch_executed,
  input wire logic fetch_discarded,
  input wire logic [3:0] interrupt_mask_level,
  output logic break_req
);
  logic [31:0] a_addr_q, a_ign_q, b_addr_q, b_ign_q, b_val_q, b_vign_q, ctrl_q;
  logic [7:0] a_sel_q, b_sel_q;
  logic [1:0] flags_q;
  // shadow copies used by the matchers
  logic [31:0] sa_addr_q, sa_ign_q, sb_addr_q, sb_ign_q, sb_val_q, sb_vign_q, sctl_q;
  logic [7:0] sa_sel_q, sb_sel_q;
  logic [1:0] settle_q;
  logic wr_pend_q;
  logic seq_armed_q;
  logic acc, wr_ok, legacy;
  logic hit_a, hit_b, ev_a, ev_b, fire;
  logic [31:0] rd_d;
  logic unmapped;

  assign acc = psel && penable;
  assign wr_ok = acc && pwrite && pmaster_cpu && !unmapped;
  assign legacy = sctl_q[CTL_LEGACY];

  always_comb begin
    unmapped = 1'b0;
    rd_d = 32'h0000_0000;
    case (paddr)
      OFS_A_ADDR: rd_d = a_addr_q;
      OFS_A_IGN: rd_d = a_ign_q;
      OFS_A_SEL: rd_d = {24'h00_0000, a_sel_q};
      OFS_B_ADDR: rd_d = b_addr_q;
      OFS_B_IGN: rd_d = b_ign_q;
      OFS_B_SEL: rd_d = {24'h00_0000, b_sel_q};
      OFS_B_VAL: rd_d = b_val_q;
      OFS_B_VIGN: rd_d = b_vign_q;
      OFS_CTRL: rd_d = ctrl_q;
      OFS_STAT: rd_d = {30'h0000_0000, flags_q};
      default: unmapped = 1'b1;
    endcase
  end

  // apb answers in the access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (unmapped || !pmaster_cpu);
      if (psel && !penable && !pwrite && pmaster_cpu && !unmapped) begin
        prdata <= rd_d;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  wire wr_take = wr_ok && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_addr_q <= 32'h0000_0000;
      a_ign_q <= 32'h0000_0000;
      a_sel_q <= SEL_RST[7:0];
      b_addr_q <= 32'h0000_0000;
      b_ign_q <= 32'h0000_0000;
      b_sel_q <= SEL_RST[7:0];
      b_val_q <= 32'h0000_0000;
      b_vign_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
    end else if (wr_take) begin
      case (paddr)
        OFS_A_ADDR: a_addr_q <= pwdata;
        OFS_A_IGN: a_ign_q <= pwdata;
        OFS_A_SEL: a_sel_q <= pwdata[7:0];
        OFS_B_ADDR: b_addr_q <= pwdata;
        OFS_B_IGN: b_ign_q <= pwdata;
        OFS_B_SEL: b_sel_q <= pwdata[7:0];
        OFS_B_VAL: b_val_q <= pwdata;
        OFS_B_VIGN: b_vign_q <= pwdata;
        OFS_CTRL: ctrl_q <= pwdata;
        default: ;
      endcase
    end
  end

  // settle delay: shadows load three cycles after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 2'h0;
      wr_pend_q <= 1'b0;
    end else if (wr_take) begin
      settle_q <= 2'(SETTLE_CYC - 2);
      wr_pend_q <= 1'b1;
    end else if (wr_pend_q && settle_q != 2'h0) begin
      settle_q <= settle_q - 2'h1;
    end else begin
      wr_pend_q <= 1'b0;
    end
  end

  wire shadow_load = wr_pend_q && settle_q == 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_addr_q <= 32'h0000_0000;
      sa_ign_q <= 32'h0000_0000;
      sa_sel_q <= SEL_RST[7:0];
      sb_addr_q <= 32'h0000_0000;
      sb_ign_q <= 32'h0000_0000;
      sb_sel_q <= SEL_RST[7:0];
      sb_val_q <= 32'h0000_0000;
      sb_vign_q <= 32'h0000_0000;
      sctl_q <= CTRL_RST;
    end else if (shadow_load) begin
      sa_addr_q <= a_addr_q;
      sb_addr_q <= b_addr_q;
      sctl_q <= ctrl_q;
      // legacy keeps masks and value compare out of play
      sa_ign_q <= ctrl_q[CTL_LEGACY] ? 32'h0000_0000 : a_ign_q;
      sb_ign_q <= ctrl_q[CTL_LEGACY] ? 32'h0000_0000 : b_ign_q;
      sa_sel_q <= a_sel_q;
      sb_sel_q <= b_sel_q;
      sb_val_q <= b_val_q;
      sb_vign_q <= ctrl_q[CTL_LEGACY] ? 32'hffff_ffff : b_vign_q;
    end
  end

  ubm_chan u_chan_a (
    .match_address(sa_addr_q),
    .address_ignore(sa_ign_q),
    .cycle_select(sa_sel_q),
    .use_value(1'b0),
    .match_value(32'h0000_0000),
    .value_ignore(32'hffff_ffff),
    .legacy(legacy),
    .bus_addr(bus_addr),
    .bus_data(bus_data),
    .bus_master(bus_master),
    .bus_kind(bus_kind),
    .bus_write(bus_write),
    .bus_size(bus_size),
    .bus_external(bus_external),
    .hit(hit_a)
  );

  ubm_chan u_chan_b (
    .match_address(sb_addr_q),
    .address_ignore(sb_ign_q),
    .cycle_select(sb_sel_q),
    .use_value(1'b1),
    .match_value(sb_val_q),
    .value_ignore(sb_vign_q),
    .legacy(legacy),
    .bus_addr(bus_addr),
    .bus_data(bus_data),
    .bus_master(bus_master),
    .bus_kind(bus_kind),
    .bus_write(bus_write),
    .bus_size(bus_size),
    .bus_external(bus_external),
    .hit(hit_b)
  );

  // fetch qualification: native after-exec counts only executed fetches, before-exec skips discarded ones
  function automatic logic qual(input logic hit, input logic after);
    if (bus_kind != KND_FETCH) begin
      qual = hit;
    end else if (legacy) begin
      qual = hit;
    end else if (after) begin
      qual = hit && fetch_executed;
    end else begin
      qual = hit && !fetch_discarded;
    end
  endfunction : qual

  // always_comb so that the globals read inside qual retrigger it
  always_comb begin
    ev_a = bus_valid && qual(hit_a, sctl_q[CTL_AFTER_A]);
    ev_b = bus_valid && qual(hit_b, sctl_q[CTL_AFTER_B]);
  end

  // sequence: b must come in a later bus cycle than a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_armed_q <= 1'b0;
    end else if (!sctl_q[CTL_SEQ]) begin
      seq_armed_q <= 1'b0;
    end else if (ev_b && seq_armed_q) begin
      seq_armed_q <= 1'b0;
    end else if (ev_a) begin
      seq_armed_q <= 1'b1;
    end
  end

  assign fire = sctl_q[CTL_SEQ] ? (ev_b && seq_armed_q) : (ev_a || ev_b);

  // break request gated by cpu mask level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_req <= 1'b0;
    end else begin
      break_req <= fire && (interrupt_mask_level <= MASK_LEVEL_MAX);
    end
  end

  // match flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!legacy && (i == 0 ? ev_a : ev_b)) begin
          flags_q[i] <= 1'b1;
        end else if (wr_take && paddr == OFS_STAT && pwdata[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  end

  a_seq_order: assert property (@(posedge pclk) disable iff (!presetn)
    (sctl_q[CTL_SEQ] && ev_a && ev_b && !seq_armed_q) |=> !break_req)
    else $error("sequence fired on same cycle");
  a_break_raise: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && interrupt_mask_level <= 4'he) |=> break_req)
    else $error("match did not raise break");
  a_mask_block: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_mask_level == 4'hf) |=> !break_req)
    else $error("break raised at mask 15");
  a_settle_three: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == OFS_CTRL) |=> ##2 (sctl_q == $past(ctrl_q, 1)))
    else $error("setting not applied after three cycles");
  a_cpu_only: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && !pmaster_cpu) |=> $stable(ctrl_q) && $stable(a_addr_q))
    else $error("non-cpu write changed registers");
  a_legacy_noflag: assert property (@(posedge pclk) disable iff (!presetn)
    (legacy && !(wr_take && paddr == OFS_STAT)) |=> !$rose(flags_q[0]) && !$rose(flags_q[1]))
    else $error("flag set in legacy mode");
  a_dma_nofetch: assert property (@(posedge pclk) disable iff (!presetn)
    (sa_sel_q[1:0] == MST_DMA && sa_sel_q[3:2] == KND_FETCH) |-> !hit_a)
    else $error("dma fetch matched");
  a_legacy_full: assert property (@(posedge pclk) disable iff (!presetn)
    (legacy && hit_a) |-> (bus_addr == sa_addr_q))
    else $error("legacy partial address match");

  a_dma_nofetch_b: assert property (@(posedge pclk) disable iff (!presetn)
    (sb_sel_q[1:0] == MST_DMA && sb_sel_q[3:2] == KND_FETCH) |-> !hit_b)
    else $error("dma fetch matched on channel b");

  a_discard_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (!legacy && bus_valid && bus_kind == KND_FETCH && fetch_discarded && !fetch_executed)
    |=> !break_req)
    else $error("discarded fetch raised break");

  a_legacy_noext: assert property (@(posedge pclk) disable iff (!presetn)
    (legacy && bus_external) |-> (!hit_a && !hit_b))
    else $error("external cycle matched in legacy mode");

  a_refuse_other: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pmaster_cpu) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("non-cpu access not refused");

  a_accept_cpu: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && pmaster_cpu && !unmapped) |=> (pready && !pslverr))
    else $error("cpu access refused");

  a_flag_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (!legacy && ev_a) |=> flags_q[0])
    else $error("native match left flag clear");

  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!bus_valid) |=> !break_req)
    else $error("break raised without bus cycle");

  a_seq_armed: assert property (@(posedge pclk) disable iff (!presetn)
    (sctl_q[CTL_SEQ] && !seq_armed_q) |=> !break_req)
    else $error("sequence fired without channel a first");

  a_seq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (!sctl_q[CTL_SEQ]) |=> !seq_armed_q)
    else $error("sequence armed outside sequential mode");

  a_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!shadow_load) |=> ($stable(sctl_q) && $stable(sa_addr_q) && $stable(sb_addr_q)))
    else $error("matcher setting changed without load");

  a_settle_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr_pend_q) |-> (settle_q == 2'h0))
    else $error("settle count running while idle");

  a_legacy_nomask: assert property (@(posedge pclk) disable iff (!presetn)
    legacy |-> (sa_ign_q == 32'h0000_0000 && sb_ign_q == 32'h0000_0000))
    else $error("address mask active in legacy mode");

  a_value_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (hit_b && !legacy) |-> (((bus_data ^ sb_val_q) & ~sb_vign_q) == 32'h0000_0000))
    else $error("channel b hit on unmasked data difference");

  a_native_word: assert property (@(posedge pclk) disable iff (!presetn)
    (!legacy && hit_a && bus_kind == KND_DATA && bus_size == SIZ_WORD)
    |-> ((((bus_addr ^ sa_addr_q) & ~sa_ign_q) & 32'hffff_fffe) == 32'h0000_0000))
    else $error("native word hit outside target word");
endmodule : ubm_top

// [tb/ubm_bus_model.sv]
`timescale 1ns/1ns
module ubm_bus_model (
  input wire logic pclk,
  input wire logic break_req,
  output logic bus_valid,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_data,
  output logic [1:0] bus_master,
  output logic [1:0] bus_kind,
  output logic bus_write,
  output logic [1:0] bus_size,
  output logic bus_external,
  output logic fetch_executed,
  output logic fetch_discarded
);
  initial begin
    bus_valid = 1'b0;
    {bus_addr, bus_data} = '1;
    {bus_master, bus_kind, bus_write, bus_size} = '0;
    {bus_external, fetch_executed, fetch_discarded} = '0;
  end
  // one cycle at a time, in program order
  task automatic cyc(input logic [31:0] a, d, input logic [1:0] m, k,
      input logic w, input logic [1:0] s, input logic x, dc, output logic hit);
    @(posedge pclk);
    bus_valid <= 1'b1;
    bus_addr <= a;
    bus_data <= d;
    bus_master <= m;
    bus_kind <= k;
    bus_write <= w;
    bus_size <= s;
    bus_external <= x;
    fetch_executed <= ~dc;
    fetch_discarded <= dc;
    @(posedge pclk);
    bus_valid <= 1'b0;
    // released address, data and write lines show the inverse, never the stale value
    bus_addr <= ~a;
    bus_data <= ~d;
    bus_write <= ~w;
    #1 hit = break_req;
  endtask : cyc
endmodule : ubm_bus_model

// [tb/user_break_match_logic_tb.sv]
`timescale 1ns/1ns
module user_break_match_logic_tb;
  import ubm_pkg::*;
  localparam logic [31:0] idle_addr = 32'hfffffff0; // unused channel never hit
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic pmaster_cpu = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] lvl = 4'h0;
  logic ext = 1'b0;
  logic disc = 1'b0;
  logic [31:0] prdata, bus_addr, bus_data;
  logic pready, pslverr, bus_valid, bus_write, bus_external;
  logic fetch_executed, fetch_discarded, break_req;
  logic [1:0] bus_master, bus_kind, bus_size;
  int fail_count = 0;
  int n_checks = 0;
  always #5 pclk = ~pclk;
  ubm_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pmaster_cpu, .prdata, .pready, .pslverr, .bus_valid, .bus_addr, .bus_data,
    .bus_master, .bus_kind, .bus_write, .bus_size, .bus_external, .fetch_executed,
    .fetch_discarded, .interrupt_mask_level(lvl), .break_req);
  ubm_bus_model i_bus (.pclk, .break_req, .bus_valid, .bus_addr, .bus_data,
    .bus_master, .bus_kind, .bus_write, .bus_size, .bus_external, .fetch_executed,
    .fetch_discarded);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic cpu, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pmaster_cpu <= cpu;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, 1'b1, rd, er);
    apb(1'b0, a, 32'h0, 1'b1, rd, er);
  endtask : wr
  task automatic cfg(input logic [31:0] aa, ai, as, ba, bi, bs, bv, bvi, ct);
    wr(OFS_A_ADDR, aa);
    wr(OFS_A_IGN, ai);
    wr(OFS_A_SEL, as);
    wr(OFS_B_ADDR, ba);
    wr(OFS_B_IGN, bi);
    wr(OFS_B_SEL, bs);
    wr(OFS_B_VAL, bv);
    wr(OFS_B_VIGN, bvi);
    wr(OFS_CTRL, ct);
  endtask : cfg
  task automatic bc(input string n, input logic [31:0] a, d, input logic [1:0] m, k,
      input logic w, input logic [1:0] s, input logic e);
    logic h;
    i_bus.cyc(a, d, m, k, w, s, ext, disc, h);
    chk(n, {31'h0, h}, {31'h0, e});
  endtask : bc
  // native: access covers target; legacy: exact address only
  function automatic logic exp_a(input logic [31:0] t, a, input int nb, input logic lg);
    return lg ? (a == t) : (t >= a && t < a + nb);
  endfunction : exp_a
  initial begin
    logic [31:0] rd, t, a;
    logic er;
    int nb;
    void'($urandom(32'h74ce));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, 1'b1, rd, er);
      chk("reset", rd, 32'h0);
    end
    apb(1'b0, 8'h30, 32'h0, 1'b1, rd, er);
    chk("unmapped", {31'h0, er}, 32'h1);
    apb(1'b1, OFS_A_ADDR, 32'h5a5a, 1'b0, rd, er);
    chk("dma wr err", {31'h0, er}, 32'h1);
    t = $urandom();
    wr(OFS_A_ADDR, t);
    apb(1'b0, OFS_A_ADDR, 32'h0, 1'b0, rd, er);
    chk("dma rd", rd, 32'h0);
    apb(1'b0, OFS_A_ADDR, 32'h0, 1'b1, rd, er);
    chk("cpu rd", rd, t);
    for (int lg = 0; lg < 2; lg++) begin
      for (int j = 0; j < 2; j++) begin
        t = 32'h00123456 + j;
        cfg(t, 0, 32'h19, idle_addr, 0, 32'h05, 0, '1, {28'h0, lg[0], 3'h0});
        for (int s = 1; s < 4; s++) begin
          nb = 1 << (s - 1);
          a = t & ~(nb - 1);
          bc("a size", a, $urandom(), MST_CPU, KND_DATA, 1'b0, 2'(s),
            exp_a(t, a, nb, lg[0]));
        end
        bc("a near", t ^ 32'h1, 0, MST_CPU, KND_DATA, 1'b0, SIZ_BYTE, 1'b0);
      end
    end
    cfg(idle_addr, 0, 32'h05, 32'h000abcde, 32'hff, 32'ha9, 32'ha512, 0, 0);
    repeat (6) begin
      a = {24'h000abc, 8'($urandom()) & 8'hfe};
      bc("b mask", a, 32'ha512, MST_CPU, KND_DATA, 1'b1, SIZ_WORD, 1'b1);
    end
    bc("b out", 32'h000abd00, 32'ha512, MST_CPU, KND_DATA, 1'b1, SIZ_WORD, 1'b0);
    bc("b data", 32'h000abcde, 32'ha513, MST_CPU, KND_DATA, 1'b1, SIZ_WORD, 1'b0);
    wr(OFS_CTRL, 32'h8);
    bc("b legacy", 32'h000abc00, 32'ha512, MST_CPU, KND_DATA, 1'b1, SIZ_WORD, 1'b0);
    cfg(32'h00314156, 0, 32'h16, 32'h00055555, 0, 32'h6a, 32'h7878, 32'h0f0f, 0);
    bc("a dma", 32'h00314156, 0, MST_DMA, KND_FETCH, 1'b0, SIZ_WORD, 1'b0);
    repeat (4) begin
      t = 32'($urandom_range(15));
      a = {16'h0, 4'h7, t[3:0], 4'h7, t[3:0]};
      bc("b dma", 32'h00055555, a, MST_DMA, KND_DATA, 1'b1, SIZ_BYTE, 1'b1);
      bc("b nib", 32'h00055555, a ^ 32'h1010, MST_DMA, KND_DATA, 1'b1, SIZ_BYTE, 1'b0);
    end
    for (int lg = 0; lg < 2; lg++) begin
      cfg(32'h100, 0, 32'h05, idle_addr, 0, 32'h05, 0, '1, {28'h0, lg[0], 3'h0});
      wr(OFS_STAT, 32'h3);
      for (int v = 13; v < 16; v++) begin
        @(posedge pclk);
        lvl <= 4'(v);
        bc("level", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, v <= MASK_LEVEL_MAX);
      end
      @(posedge pclk);
      lvl <= 4'h0;
      disc = 1'b1;
      bc("discard", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, lg[0]);
      disc = 1'b0;
      ext = 1'b1;
      bc("external", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, ~lg[0]);
      ext = 1'b0;
      apb(1'b0, OFS_STAT, 32'h0, 1'b1, rd, er);
      chk("flags", rd, {31'h0, ~lg[0]});
    end
    wr(OFS_CTRL, 32'h2);
    disc = 1'b1;
    bc("after skip", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, 1'b0);
    disc = 1'b0;
    bc("after run", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, 1'b1);
    cfg(32'h100, 0, 32'h05, 32'h200, 0, 32'h05, 0, '1, 32'h1);
    bc("seq b1", 32'h200, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, 1'b0);
    bc("seq a", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, 1'b0);
    bc("seq b2", 32'h200, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, 1'b1);
    wr(OFS_B_ADDR, 32'h100);
    bc("seq same", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, 1'b0);
    bc("seq next", 32'h100, 0, MST_CPU, KND_FETCH, 1'b0, SIZ_WORD, 1'b1);
    print_verdict();
  end
endmodule : user_break_match_logic_tb
